// [design/ccbfe_pkg.sv]
package ccbfe_pkg;
   // Guest strobe timing for the codec host port, in PCI clocks.
   localparam int START_STROBE_CYCLES = 12;
   localparam int START_RECOVERY_CYCLES = 3;
   // Codec memory address of the start command.
   localparam logic [9:0] START_CODEC_ADDR = 10'h000;
   // Settling times around host relay accesses, in PCI clocks.
   localparam int RELAY_DISABLE_WAIT = 15;
   localparam int RELAY_ENABLE_HOLD = 5;
   // AXI4-Lite register offsets of the codec-side model controller.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_MASK = 4'h8;
   localparam logic [3:0] REG_COUNT = 4'hC;
   // Control register bit positions.
   localparam int CTRL_RUN = 0;
   localparam int CTRL_DIR = 1;
   localparam int CTRL_LEN_LSB = 8;
   localparam int CTRL_LEN_W = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [1:0] MASK_RESET = 2'h0;
   // Status event bits.
   localparam int EV_DONE = 0;
   localparam int EV_START = 1;
   // Link clock divider: half period in system clocks.
   localparam int LINK_HALF = 8;
   localparam int PTR_W = 8;
endpackage

// [design/ccbfe_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ccbfe_if;
   logic double_video_clock;
   logic code_chip_select_n;
   logic code_block_signal_n;
   logic [7:0] code_from_codec;
   logic [7:0] code_to_codec;
   logic code_to_codec_oe;
   logic end_of_field_n;
   logic start_strobe_n;
   logic [2:0] start_guest_identity;
   logic [2:0] start_guest_register;
   logic [1:0] guest_address_lines;
   logic [7:0] guest_data_bus;
   modport front_end (
      input double_video_clock, code_chip_select_n, code_from_codec, end_of_field_n,
      output code_block_signal_n, code_to_codec, code_to_codec_oe, start_strobe_n,
      start_guest_identity, start_guest_register, guest_address_lines, guest_data_bus
   );
   modport codec (
      output double_video_clock, code_chip_select_n, code_from_codec, end_of_field_n,
      input code_block_signal_n, code_to_codec, code_to_codec_oe, start_strobe_n,
      start_guest_identity, start_guest_register, guest_address_lines, guest_data_bus
   );
endinterface
`default_nettype wire

// [design/ccbfe_front_end.sv]
`timescale 1ns/1ps
`default_nettype none
module ccbfe_front_end #(
   parameter int DEPTH = 16,
   parameter logic [2:0] START_ID = 3'h0,
   parameter logic [2:0] START_REG = 3'h0
) (
   input wire logic aclk,
   input wire logic aresetn,
   ccbfe_if.front_end link,
   input wire logic decompress,
   input wire logic start_enable,
   input wire logic field_delivered,
   input wire logic [7:0] push_data,
   input wire logic push_valid,
   output logic push_ready,
   output logic [7:0] pop_data,
   output logic pop_valid,
   input wire logic pop_ready,
   output logic field_finished_flag,
   input wire logic field_finished_clear,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 4 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two, at least 4");
   end
   ////////////////////////////////////////////////////////////////////////////////
   logic [2:0] clk_sync;
   logic [1:0] cs_sync;
   logic [1:0] eof_sync;
   logic [7:0] data_s1;
   logic [7:0] data_s2;
   logic rise;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_sync <= 3'h0;
         cs_sync <= 2'h3;
         eof_sync <= 2'h3;
         data_s1 <= 8'h00;
         data_s2 <= 8'h00;
      end else begin
         clk_sync <= {clk_sync[1:0], link.double_video_clock};
         cs_sync <= {cs_sync[0], link.code_chip_select_n};
         eof_sync <= {eof_sync[0], link.end_of_field_n};
         data_s1 <= link.code_from_codec;
         data_s2 <= data_s1;
      end
   end
   // The link clock is oversampled; only rises after the second stage are seen.
   assign rise = clk_sync[1] & ~clk_sync[2];
   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] mem [DEPTH];
   logic [AW:0] wptr;
   logic [AW:0] rptr;
   logic [AW:0] fill;
   logic wr_en;
   logic rd_en;
   logic selected;
   assign selected = ~cs_sync[1];
   assign wr_en = decompress ? (push_valid && push_ready)
                             : (rise && selected && fill != (AW+1)'(DEPTH));
   assign rd_en = decompress ? (rise && selected && fill != '0)
                             : (pop_valid && pop_ready);
   always_ff @(posedge aclk) begin
      if (wr_en) begin
         mem[wptr[AW-1:0]] <= decompress ? push_data : data_s2;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         if (wr_en) wptr <= wptr + 1'b1;
         if (rd_en) rptr <= rptr + 1'b1;
      end
   end
   assign fill = wptr - rptr;
   // The reported level is registered so that no path runs straight out to the port.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level <= '0;
      end else begin
         level <= fill;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         push_ready <= 1'b0;
         pop_valid <= 1'b0;
         pop_data <= 8'h00;
      end else begin
         push_ready <= decompress && fill < (AW+1)'(DEPTH - 2);
         pop_valid <= !decompress && fill != '0 && !(pop_valid && pop_ready);
         pop_data <= mem[rptr[AW-1:0]];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Compression raises busy with margin: the codec sees it one link cycle late,
   // and the synchronisers add more delay on top. Decompression waits for an empty
   // FIFO, since a byte held back there would never reach the codec.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link.code_block_signal_n <= 1'b1;
      end else if (decompress) begin
         link.code_block_signal_n <= (fill != '0);
      end else begin
         link.code_block_signal_n <= !(fill >= (AW+1)'(DEPTH - 3));
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link.code_to_codec <= 8'h00;
         link.code_to_codec_oe <= 1'b0;
      end else begin
         link.code_to_codec_oe <= decompress && selected;
         if (rd_en && decompress) link.code_to_codec <= mem[rptr[AW-1:0]];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         field_finished_flag <= 1'b0;
      end else if (!eof_sync[1]) begin
         field_finished_flag <= 1'b1;
      end else if (field_finished_clear) begin
         field_finished_flag <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {ccbfe_idle, ccbfe_strobe, ccbfe_recover} ccbfe_go_t;
   ccbfe_go_t go_state;
   logic pending;
   logic [4:0] go_cnt;
   logic filled;
   logic filled_q;
   assign filled = fill >= (AW+1)'(DEPTH - 2);
   // In decompression only the rise of filled asks for a start, so a FIFO that stays full issues one.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         filled_q <= 1'b0;
      end else begin
         filled_q <= filled;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending <= 1'b0;
      end else if ((field_delivered && !decompress) || (decompress && filled && !filled_q)) begin
         pending <= 1'b1;
      end else if (go_state == ccbfe_idle && start_enable) begin
         pending <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         go_state <= ccbfe_idle;
         go_cnt <= 5'h00;
         link.start_strobe_n <= 1'b1;
         link.start_guest_identity <= 3'h0;
         link.start_guest_register <= 3'h0;
         link.guest_address_lines <= 2'h0;
         link.guest_data_bus <= 8'h00;
      end else begin
         case (go_state)
            ccbfe_idle: begin
               if (pending && start_enable) begin
                  go_state <= ccbfe_strobe;
                  go_cnt <= 5'(ccbfe_pkg::START_STROBE_CYCLES - 1);
                  link.start_strobe_n <= 1'b0;
                  link.start_guest_identity <= START_ID;
                  link.start_guest_register <= START_REG;
                  link.guest_address_lines <= ccbfe_pkg::START_CODEC_ADDR[9:8];
                  link.guest_data_bus <= 8'h00;
               end
            end
            ccbfe_strobe: begin
               if (go_cnt == 5'h00) begin
                  go_state <= ccbfe_recover;
                  go_cnt <= 5'(ccbfe_pkg::START_RECOVERY_CYCLES - 1);
                  link.start_strobe_n <= 1'b1;
               end else begin
                  go_cnt <= go_cnt - 5'h01;
               end
            end
            ccbfe_recover: begin
               if (go_cnt == 5'h00) go_state <= ccbfe_idle;
               else go_cnt <= go_cnt - 5'h01;
            end
            default: go_state <= ccbfe_idle;
         endcase
      end
   end
endmodule
`default_nettype wire

// [design/ccbfe_codec.sv]
`timescale 1ns/1ps
`default_nettype none
// Codec-side model controller: drives the link clock and select, counts
// bytes in bursts, and reports over AXI4-Lite.
module ccbfe_codec (
   input wire logic aclk,
   input wire logic aresetn,
   ccbfe_if.codec link,
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic irq
);
   logic [31:0] ctrl;
   logic [1:0] status;
   logic [1:0] mask;
   logic [15:0] count;
   logic [3:0] div;
   logic [1:0] busy_sync;
   logic [1:0] strobe_sync;
   logic link_clk;
   logic ev_done;
   logic ev_start;
   logic aw_hold;
   logic w_hold;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic rd_status;
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div <= 4'h0;
         link_clk <= 1'b0;
         busy_sync <= 2'h3;
         strobe_sync <= 2'h3;
      end else begin
         div <= (div == 4'(ccbfe_pkg::LINK_HALF - 1)) ? 4'h0 : div + 4'h1;
         if (div == 4'(ccbfe_pkg::LINK_HALF - 1)) link_clk <= ~link_clk;
         busy_sync <= {busy_sync[0], link.code_block_signal_n};
         strobe_sync <= {strobe_sync[0], link.start_strobe_n};
      end
   end
   assign link.double_video_clock = link_clk;
   // Action happens just before the rising edge, so busy is checked one cycle ahead.
   logic fall_due;
   assign fall_due = (div == 4'(ccbfe_pkg::LINK_HALF - 1)) && !link_clk;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link.code_chip_select_n <= 1'b1;
         link.code_from_codec <= 8'h00;
         link.end_of_field_n <= 1'b1;
         count <= 16'h0000;
         rx_byte <= 8'h00;
         rx_valid <= 1'b0;
         ev_done <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         ev_done <= 1'b0;
         link.end_of_field_n <= 1'b1;
         if (fall_due) begin
            // The byte popped on the previous link rise is taken here even when the
            // burst ends or pauses, so the last byte before select rises is kept.
            if (ctrl[ccbfe_pkg::CTRL_DIR] && !link.code_chip_select_n) begin
               rx_byte <= link.code_to_codec;
               rx_valid <= 1'b1;
            end
            if (ctrl[ccbfe_pkg::CTRL_RUN] && busy_sync[1] && count != ctrl[23:8]) begin
               link.code_chip_select_n <= 1'b0;
               link.code_from_codec <= tx_byte;
               count <= count + 16'h0001;
            end else begin
               link.code_chip_select_n <= 1'b1;
               if (count == ctrl[23:8] && count != 16'h0000) begin
                  link.end_of_field_n <= 1'b0;
                  ev_done <= 1'b1;
                  count <= 16'h0000;
               end
            end
         end
      end
   end
   assign ev_start = strobe_sync[1] && !strobe_sync[0];
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= 2'h0;
         ctrl <= ccbfe_pkg::CTRL_RESET;
         mask <= ccbfe_pkg::MASK_RESET;
      end else begin
         awready <= !aw_hold && !awready && !bvalid;
         wready <= !w_hold && !wready && !bvalid;
         if (awvalid && awready) begin
            aw_hold <= 1'b1;
            aw_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold <= 1'b1;
            w_data <= wdata;
         end
         if (aw_hold && w_hold && !bvalid) begin
            bvalid <= 1'b1;
            bresp <= 2'h0;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            case (aw_addr)
               ccbfe_pkg::REG_CTRL: ctrl <= w_data;
               ccbfe_pkg::REG_MASK: mask <= w_data[1:0];
               ccbfe_pkg::REG_STATUS: ;
               ccbfe_pkg::REG_COUNT: ;
               default: bresp <= 2'h2;
            endcase
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'h0;
         rd_status <= 1'b0;
      end else begin
         arready <= !arready && !rvalid;
         rd_status <= 1'b0;
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= 2'h0;
            case (araddr)
               ccbfe_pkg::REG_CTRL: rdata <= ctrl;
               ccbfe_pkg::REG_STATUS: begin
                  rdata <= {30'h0, status};
                  rd_status <= 1'b1;
               end
               ccbfe_pkg::REG_MASK: rdata <= {30'h0, mask};
               ccbfe_pkg::REG_COUNT: rdata <= {16'h0000, count};
               default: begin
                  rdata <= 32'h0000_0000;
                  rresp <= 2'h2;
               end
            endcase
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end
   // Set wins over the read clear, but an event set on the edge where the read samples status is lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= 2'h0;
         irq <= 1'b0;
      end else begin
         status[ccbfe_pkg::EV_DONE] <= ev_done | (status[ccbfe_pkg::EV_DONE] & ~rd_status);
         status[ccbfe_pkg::EV_START] <= ev_start | (status[ccbfe_pkg::EV_START] & ~rd_status);
         irq <= |(status & mask);
      end
   end
endmodule
`default_nettype wire

// [verif/ccbfe_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ccbfe_chk #(
   parameter logic [2:0] START_ID = 3'h0,
   parameter logic [2:0] START_REG = 3'h0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic double_video_clock,
   input wire logic code_chip_select_n,
   input wire logic [7:0] code_from_codec,
   input wire logic code_to_codec_oe,
   input wire logic start_strobe_n,
   input wire logic [2:0] start_guest_identity,
   input wire logic [2:0] start_guest_register,
   input wire logic [1:0] guest_address_lines
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////
   // Counting the low time lets one check span the whole strobe.
   logic [7:0] low_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn || start_strobe_n) begin
         low_cnt <= 8'h00;
      end else begin
         low_cnt <= low_cnt + 8'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   strobe_len_a: assert property (
      $rose(start_strobe_n) |-> low_cnt == 8'(ccbfe_pkg::START_STROBE_CYCLES))
      else $error("start strobe low time wrong");
   strobe_recovery_a: assert property (
      $rose(start_strobe_n) |-> start_strobe_n [*3])
      else $error("start strobe recovery too short");
   start_target_a: assert property (
      !start_strobe_n |-> start_guest_identity == START_ID
         && start_guest_register == START_REG
         && guest_address_lines == ccbfe_pkg::START_CODEC_ADDR[9:8])
      else $error("start command target wrong");
   drive_idle_a: assert property (
      code_chip_select_n [*6] |-> !code_to_codec_oe)
      else $error("code bus driven while not selected");
   drive_start_a: assert property (
      $rose(code_to_codec_oe) |-> !code_chip_select_n)
      else $error("code bus drive began without select");
   link_half_a: assert property (
      $rose(double_video_clock) |-> double_video_clock [*8])
      else $error("link clock high phase too short");
   code_hold_a: assert property (
      !code_chip_select_n && double_video_clock && $past(double_video_clock)
         |-> $stable(code_from_codec))
      else $error("code byte changed within link high phase");
   select_hold_a: assert property (
      $fell(code_chip_select_n) |-> !code_chip_select_n [*8])
      else $error("select released too early");
endmodule
`default_nettype wire

// [verif/ccbfe_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ccbfe_bench;
   logic aclk = 1'b0, aresetn = 1'b0, decompress = 1'b0, start_enable = 1'b0;
   logic field_delivered = 1'b0, push_valid = 1'b0, pop_ready = 1'b0, ff_clear = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] push_data = 8'h00, tx_byte = 8'h00, rnd = 8'h52;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic push_ready, pop_valid, fflag, awready, wready, bvalid, arready, rvalid, rx_valid, irq;
   logic [7:0] pop_data, rx_byte;
   logic [4:0] level;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int n_errors = 0, num_checks = 0;
   logic [7:0] exp_pop[$], exp_rx[$];
   logic [31:0] exp_rd[$], msk_rd[$];
   always #5 aclk = ~aclk;
   ccbfe_if link_if();
   ccbfe_front_end #(.DEPTH(16), .START_ID(3'h5), .START_REG(3'h2)) ccbfe_front_end_i (
      .aclk(aclk), .aresetn(aresetn), .link(link_if), .decompress(decompress),
      .start_enable(start_enable), .field_delivered(field_delivered),
      .push_data(push_data), .push_valid(push_valid), .push_ready(push_ready),
      .pop_data(pop_data), .pop_valid(pop_valid), .pop_ready(pop_ready),
      .field_finished_flag(fflag), .field_finished_clear(ff_clear), .level(level));
   ccbfe_codec ccbfe_codec_i (
      .aclk(aclk), .aresetn(aresetn), .link(link_if), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .tx_byte(tx_byte), .rx_byte(rx_byte), .rx_valid(rx_valid), .irq(irq));
   ccbfe_chk #(.START_ID(3'h5), .START_REG(3'h2)) ccbfe_chk_i (
      .aclk(aclk), .aresetn(aresetn), .double_video_clock(link_if.double_video_clock),
      .code_chip_select_n(link_if.code_chip_select_n),
      .code_from_codec(link_if.code_from_codec), .code_to_codec_oe(link_if.code_to_codec_oe),
      .start_strobe_n(link_if.start_strobe_n),
      .start_guest_identity(link_if.start_guest_identity),
      .start_guest_register(link_if.start_guest_register),
      .guest_address_lines(link_if.guest_address_lines));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic test_done();
      if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      check32({30'h0, bresp}, 32'h0);
   endtask
   task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
                         input logic [1:0] resp);
      @(posedge aclk);
      exp_rd.push_back(e);
      msk_rd.push_back(m);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      check32({30'h0, rresp}, {30'h0, resp});
   endtask
   task automatic push(input int n);
      @(posedge aclk);
      for (int i = 0; i < n; i++) begin
         rnd = lfsr(rnd);
         push_data <= rnd;
         push_valid <= 1'b1;
         exp_rx.push_back(rnd);
         do @(posedge aclk); while (push_ready !== 1'b1);
      end
      push_valid <= 1'b0;
   endtask
   task automatic drain();
      for (int i = 0; i < 3000 && (exp_pop.size() + exp_rx.size()) > 0; i++) @(posedge aclk);
      check32(32'(exp_pop.size() + exp_rx.size()), 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Results are compared in arrival order, so any drop or duplicate shows.
   always @(posedge aclk) begin
      if (pop_valid === 1'b1 && pop_ready) check8(pop_data, exp_pop.pop_front());
      if (rx_valid === 1'b1) check8(rx_byte, exp_rx.pop_front());
      if (rvalid === 1'b1 && rready) check32(rdata & msk_rd.pop_front(), exp_rd.pop_front());
   end
   initial begin
      repeat (40000) @(posedge aclk);
      n_errors++;
      test_done();
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(ccbfe_pkg::REG_CTRL, ccbfe_pkg::CTRL_RESET, 32'hFFFF_FFFF, 2'h0);
      axi_rd(ccbfe_pkg::REG_MASK, {30'h0, ccbfe_pkg::MASK_RESET}, 32'h3, 2'h0);
      axi_rd(4'h2, 32'h0, 32'h0, 2'h2);
      axi_wr(ccbfe_pkg::REG_MASK, 32'h1);
      // A burst longer than the FIFO with the drain stalled must be blocked.
      rnd = lfsr(rnd);
      tx_byte <= rnd;
      repeat (20) exp_pop.push_back(rnd);
      axi_wr(ccbfe_pkg::REG_CTRL, 32'h0000_1401);
      repeat (700) @(posedge aclk);
      check32({31'h0, link_if.code_block_signal_n}, 32'h0);
      check32({27'h0, level}, 32'h0000_000D);
      pop_ready <= 1'b1;
      drain();
      // Done follows the last byte by a link cycle; the codec is stopped at once so
      // that it cannot open another burst.
      for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge aclk);
      axi_wr(ccbfe_pkg::REG_CTRL, 32'h0);
      check32({31'h0, irq}, 32'h1);
      check32({31'h0, fflag}, 32'h1);
      axi_rd(ccbfe_pkg::REG_STATUS, 32'h1, 32'h1, 2'h0);
      axi_rd(ccbfe_pkg::REG_STATUS, 32'h0, 32'h1, 2'h0);
      ff_clear <= 1'b1;
      repeat (2) @(posedge aclk);
      ff_clear <= 1'b0;
      check32({31'h0, irq}, 32'h0);
      check32({31'h0, fflag}, 32'h0);
      // Decompression: the second burst outruns the FIFO until it is refilled.
      decompress <= 1'b1;
      push(10);
      axi_wr(ccbfe_pkg::REG_CTRL, 32'h0000_0603);
      for (int i = 0; i < 3000 && exp_rx.size() > 4; i++) @(posedge aclk);
      axi_wr(ccbfe_pkg::REG_CTRL, 32'h0);
      axi_wr(ccbfe_pkg::REG_CTRL, 32'h0000_0803);
      repeat (500) @(posedge aclk);
      check32({31'h0, link_if.code_block_signal_n}, 32'h0);
      push(4);
      drain();
      axi_wr(ccbfe_pkg::REG_CTRL, 32'h0);
      // A start requested while disabled waits for the enable.
      decompress <= 1'b0;
      field_delivered <= 1'b1;
      @(posedge aclk);
      field_delivered <= 1'b0;
      repeat (40) @(posedge aclk);
      check32({31'h0, link_if.start_strobe_n}, 32'h1);
      start_enable <= 1'b1;
      for (int i = 0; i < 200 && link_if.start_strobe_n !== 1'b0; i++) @(posedge aclk);
      check32({31'h0, link_if.start_strobe_n}, 32'h0);
      start_enable <= 1'b0;
      repeat (ccbfe_pkg::RELAY_DISABLE_WAIT) @(posedge aclk);
      check32({31'h0, link_if.start_strobe_n}, 32'h1);
      repeat (40) @(posedge aclk);
      axi_rd(ccbfe_pkg::REG_STATUS, 32'h2, 32'h2, 2'h0);
      test_done();
   end
endmodule
`default_nettype wire
